/* File: core/loopback_device.sv */
// Mobile-side switched radio block loopback with multi-slot mapping.
// Assumes the tester pulses blk_tick once per block period, at least
// nine cycles apart, and sends each downlink block within a period.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "loopback_map.svh"

module loopback_device #(
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Radio link
  loopback_if.device link,
  // Configuration
  input wire logic i_multislot_en,
  input wire logic [7:0] i_dl_ts_mask,
  input wire logic [7:0] i_ul_ts_mask,
  input wire logic [2:0] i_dl_offset,
  input wire logic i_t3190_expired,
  // Own uplink traffic
  input wire logic i_own_valid,
  input wire logic [2:0] i_own_slot,
  input wire logic [DW-1:0] i_own_data,
  // Upper layers
  output logic o_llc_valid,
  output logic [DW-1:0] o_llc_data,
  output logic o_rlc_valid,
  output logic o_rlc_ctrl,
  output logic [DW-1:0] o_rlc_data,
  // Status
  output logic o_loop_active,
  output logic o_submode_on,
  output logic o_timers_hold,
  output logic o_own_tx_allow
);
  import loopback_pkg::*;

  // -----------------------------------------------------------------------
  // Slot mapping
  // -----------------------------------------------------------------------
  // Downlink slot feeding the uplink slot of rank n; the count runs from the offset
  // and wraps, so an offset past the last active slot still finds one.
  function automatic logic [2:0] src_slot(input logic [2:0] n,
                                          input logic [7:0] mask,
                                          input logic [2:0] offs,
                                          input logic multi);
    logic [2:0] s;
    logic [2:0] first;
    logic [2:0] last;
    logic [2:0] pick;
    logic [3:0] cnt;
    logic got;
    first = offs;
    last = offs;
    pick = offs;
    cnt = 4'h0;
    got = 1'b0;
    for (int k = 0; k < `LB_SLOTS; k++) begin
      s = 3'(offs + 3'(k));
      if (mask[s]) begin
        if (cnt == 4'h0) begin
          first = s;
        end
        if (!got && cnt == {1'b0, n}) begin
          pick = s;
          got = 1'b1;
        end
        last = s;
        cnt = 4'(cnt + 4'h1);
      end
    end
    if (!got) begin
      pick = last;
    end
    if (!multi || cnt <= 4'h1) begin
      pick = first;
    end
    return pick;
  endfunction

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  dev_state_type state_reg;
  dev_state_type state_next;
  logic on_reg;
  logic [DW-1:0] cap_reg [`LB_SLOTS];
  logic [7:0] cap_vld_reg;
  logic [DW-1:0] tx_reg [`LB_SLOTS];
  logic [7:0] tx_vld_reg;
  logic sending_reg;
  logic [2:0] ul_idx_reg;
  logic ul_req_reg;
  logic ul_valid_reg;
  logic [2:0] ul_slot_reg;
  logic [DW-1:0] ul_data_reg;

  wire looping = (state_reg == DEV_LOOP);
  wire terminate = link.tbf_release | i_t3190_expired;
  wire want_on = ~link.dl_ptype[`LB_PTYPE_OFF_BIT];
  wire mode_cmd = looping & link.dl_valid & link.dl_ctrl;
  wire toggle = mode_cmd & (want_on != on_reg);
  // Mapping pairs slots by rank among the active ones, not by number
  wire [7:0] ul_below = i_ul_ts_mask & 8'((8'h01 << ul_idx_reg) - 8'h01);
  wire [2:0] ul_rank = 3'($countones(ul_below));
  wire [2:0] src = src_slot(ul_rank, i_dl_ts_mask, i_dl_offset,
                            i_multislot_en);
  wire loop_send = sending_reg & on_reg & i_ul_ts_mask[ul_idx_reg]
                   & tx_vld_reg[src];
  wire own_send = looping & ~on_reg & i_own_valid;
  wire capture = looping & link.dl_valid;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DEV_IDLE: begin
        if (link.start_cmd) begin
          state_next = DEV_REQ;
        end
      end
      DEV_REQ: begin
        if (terminate) begin
          state_next = DEV_IDLE;
        end else if (link.ul_assign) begin
          state_next = DEV_LOOP;
        end
      end
      DEV_LOOP: begin
        if (terminate) begin
          state_next = DEV_IDLE;
        end
      end
      default: begin
        state_next = DEV_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // Control and sub-mode
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= DEV_IDLE;
      on_reg <= 1'b1;
      ul_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ul_req_reg <= (state_next == DEV_REQ);
      if (state_reg != DEV_LOOP) begin
        on_reg <= 1'b1;
      end else if (toggle) begin
        on_reg <= want_on;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Per-slot block buffers
  // -----------------------------------------------------------------------
  // Data words hold no reset; only their valid bits matter.
  always_ff @(posedge i_clk) begin
    if (capture) begin
      cap_reg[link.dl_slot] <= link.dl_data;
    end
    if (link.blk_tick) begin
      tx_reg <= cap_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap_vld_reg <= 8'h00;
      tx_vld_reg <= 8'h00;
      sending_reg <= 1'b0;
      ul_idx_reg <= 3'h0;
    end else if (!looping || terminate) begin
      cap_vld_reg <= 8'h00;
      tx_vld_reg <= 8'h00;
      sending_reg <= 1'b0;
      ul_idx_reg <= 3'h0;
    end else if (link.blk_tick) begin
      tx_vld_reg <= cap_vld_reg;
      cap_vld_reg <= capture ? (8'h01 << link.dl_slot) : 8'h00;
      sending_reg <= 1'b1;
      ul_idx_reg <= 3'h0;
    end else begin
      if (capture) begin
        cap_vld_reg[link.dl_slot] <= 1'b1;
      end
      if (sending_reg) begin
        ul_idx_reg <= 3'(ul_idx_reg + 3'h1);
        if (ul_idx_reg == 3'h7) begin
          sending_reg <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Uplink and upper-layer outputs
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ul_valid_reg <= 1'b0;
      ul_slot_reg <= 3'h0;
      ul_data_reg <= '0;
      o_llc_valid <= 1'b0;
      o_llc_data <= '0;
      o_rlc_valid <= 1'b0;
      o_rlc_ctrl <= 1'b0;
      o_rlc_data <= '0;
      o_loop_active <= 1'b0;
      o_submode_on <= 1'b0;
      o_timers_hold <= 1'b0;
      o_own_tx_allow <= 1'b0;
    end else begin
      ul_valid_reg <= ~terminate & (loop_send | own_send);
      if (loop_send) begin
        ul_slot_reg <= ul_idx_reg;
        ul_data_reg <= tx_reg[src];
      end else if (own_send) begin
        ul_slot_reg <= i_own_slot;
        ul_data_reg <= i_own_data;
      end
      o_llc_valid <= link.dl_valid & ~link.dl_ctrl & link.dl_hdr_ok
                     & (state_reg == DEV_IDLE);
      o_llc_data <= link.dl_data;
      o_rlc_valid <= capture & link.dl_hdr_ok;
      o_rlc_ctrl <= link.dl_ctrl;
      o_rlc_data <= link.dl_data;
      o_loop_active <= (state_next == DEV_LOOP);
      o_submode_on <= (state_next == DEV_LOOP) & (toggle ? want_on : on_reg);
      o_timers_hold <= (state_next != DEV_IDLE);
      o_own_tx_allow <= (state_next == DEV_LOOP)
                        & ~(toggle ? want_on : on_reg);
    end
  end

  assign link.ul_req = ul_req_reg;
  assign link.ul_valid = ul_valid_reg;
  assign link.ul_slot = ul_slot_reg;
  assign link.ul_data = ul_data_reg;

endmodule

/* File: core/loopback_map.svh */
// Offsets, field positions and timing counts of the radio block loopback.
// Assumes a 250 MHz core clock; all timings are counted in its cycles.
`ifndef LOOPBACK_MAP_SVH
`define LOOPBACK_MAP_SVH

// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
`define LB_CLK_MHZ 250
`define LB_BLOCK_CYCLES 64
`define LB_TT02_US 1000
`define LB_TT02_CYCLES (`LB_TT02_US * `LB_CLK_MHZ)
`define LB_TT03_US 100
`define LB_TT03_CYCLES (`LB_TT03_US * `LB_CLK_MHZ)
`define LB_SLOTS 8

// -------------------------------------------------------------------------
// Payload type field (bit 8 at [1], bit 7 at [0])
// -------------------------------------------------------------------------
`define LB_PTYPE_OFF_BIT 0

// -------------------------------------------------------------------------
// Test equipment register offsets and fields
// -------------------------------------------------------------------------
`define LB_REG_CTRL 8'h00
`define LB_REG_TXDATA 8'h04
`define LB_REG_TXCTL 8'h08
`define LB_REG_STATUS 8'h0c
`define LB_REG_RXDATA 8'h10
`define LB_REG_RXSLOT 8'h14
`define LB_CTRL_START 0
`define LB_CTRL_RELEASE 1
`define LB_CTRL_SEND 2
`define LB_TXCTL_CTRL 3
`define LB_TXCTL_PT_LO 4
`define LB_TXCTL_HDR 6
`define LB_STAT_TT02 2
`define LB_STAT_RXNEW 3
`define LB_TXCTL_RESET 32'h0000_0040

`endif

/* File: core/loopback_pkg.sv */
// Types shared by both ends of the radio block loopback link.
// Assumes the constants of loopback_map.svh for the numbers themselves.
package loopback_pkg;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_REQ = 2'b01,
    DEV_LOOP = 2'b10
  } dev_state_type;

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_TT02 = 2'b01,
    SS_TT03 = 2'b10,
    SS_RUN = 2'b11
  } ss_state_type;

endpackage

/* File: core/loopback_if.sv */
// Radio link between the mobile device and the test equipment.
// Assumes both ends share one clock; the test equipment sets block timing.
interface loopback_if #(parameter int DW = 32);
  logic blk_tick;
  logic start_cmd;
  logic ul_assign;
  logic tbf_release;
  logic dl_valid;
  logic [2:0] dl_slot;
  logic dl_ctrl;
  logic [1:0] dl_ptype;
  logic dl_hdr_ok;
  logic [DW-1:0] dl_data;
  logic ul_req;
  logic ul_valid;
  logic [2:0] ul_slot;
  logic [DW-1:0] ul_data;

  modport device (
    input blk_tick, start_cmd, ul_assign, tbf_release, dl_valid, dl_slot,
    input dl_ctrl, dl_ptype, dl_hdr_ok, dl_data,
    output ul_req, ul_valid, ul_slot, ul_data
  );

  modport tester (
    output blk_tick, start_cmd, ul_assign, tbf_release, dl_valid, dl_slot,
    output dl_ctrl, dl_ptype, dl_hdr_ok, dl_data,
    input ul_req, ul_valid, ul_slot, ul_data
  );
endinterface

/* File: core/loopback_tester.sv */
// Test equipment end: starts the loopback, times TT02 and TT03, sends
// downlink blocks and collects the looped uplink blocks.
// Assumes software drives the plain register port, one strobe a cycle.
`include "loopback_map.svh"

module loopback_tester #(
  parameter int DW = 32,
  parameter int BLOCK_CYCLES = `LB_BLOCK_CYCLES,
  parameter int TT02_CYCLES = `LB_TT02_CYCLES,
  parameter int TT03_CYCLES = `LB_TT03_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Radio link
  loopback_if.tester link
);
  import loopback_pkg::*;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  ss_state_type state_reg;
  logic [31:0] timer_reg;
  logic [15:0] blk_cnt_reg;
  logic tick_reg;
  logic tt02_exp_reg;
  logic [DW-1:0] txdata_reg;
  logic [31:0] txctl_reg;
  logic [DW-1:0] rxdata_reg;
  logic [2:0] rxslot_reg;
  logic rxnew_reg;
  logic start_reg;
  logic assign_reg;
  logic release_reg;
  logic dl_valid_reg;

  wire wr_ctrl = i_wr & (i_addr == `LB_REG_CTRL);
  wire do_start = wr_ctrl & i_wdata[`LB_CTRL_START] & (state_reg == SS_IDLE);
  wire do_release = wr_ctrl & i_wdata[`LB_CTRL_RELEASE];
  // Blocks are only sent once TT03 has run out
  wire do_send = wr_ctrl & i_wdata[`LB_CTRL_SEND] & (state_reg == SS_RUN);
  wire rd_rx = i_rd & (i_addr == `LB_REG_RXDATA);
  wire [31:0] status = {28'h0, rxnew_reg, tt02_exp_reg, 2'(state_reg)};

  // -----------------------------------------------------------------------
  // Block period divider
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blk_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (blk_cnt_reg == 16'(BLOCK_CYCLES - 1));
      if (blk_cnt_reg == 16'(BLOCK_CYCLES - 1)) begin
        blk_cnt_reg <= 16'h0000;
      end else begin
        blk_cnt_reg <= 16'(blk_cnt_reg + 16'h1);
      end
    end
  end

  // -----------------------------------------------------------------------
  // Procedure sequencing
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= SS_IDLE;
      timer_reg <= 32'h0;
      tt02_exp_reg <= 1'b0;
      start_reg <= 1'b0;
      assign_reg <= 1'b0;
      release_reg <= 1'b0;
    end else begin
      start_reg <= do_start;
      assign_reg <= 1'b0;
      release_reg <= do_release;
      if (do_release) begin
        state_reg <= SS_IDLE;
      end else begin
        unique case (state_reg)
          SS_IDLE: begin
            if (do_start) begin
              state_reg <= SS_TT02;
              timer_reg <= 32'(TT02_CYCLES);
              tt02_exp_reg <= 1'b0;
            end
          end
          SS_TT02: begin
            if (link.ul_req) begin
              state_reg <= SS_TT03;
              assign_reg <= 1'b1;
              timer_reg <= 32'(TT03_CYCLES);
            end else if (timer_reg == 32'h0) begin
              state_reg <= SS_IDLE;
              tt02_exp_reg <= 1'b1;
            end else begin
              timer_reg <= 32'(timer_reg - 32'h1);
            end
          end
          SS_TT03: begin
            if (timer_reg == 32'h0) begin
              state_reg <= SS_RUN;
            end else begin
              timer_reg <= 32'(timer_reg - 32'h1);
            end
          end
          SS_RUN: begin
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // Registers and downlink/uplink data
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      txdata_reg <= '0;
      txctl_reg <= `LB_TXCTL_RESET;
      rxdata_reg <= '0;
      rxslot_reg <= 3'h0;
      rxnew_reg <= 1'b0;
      dl_valid_reg <= 1'b0;
      o_rdata <= 32'h0;
    end else begin
      dl_valid_reg <= do_send;
      if (i_wr && i_addr == `LB_REG_TXDATA) begin
        txdata_reg <= DW'(i_wdata);
      end
      if (i_wr && i_addr == `LB_REG_TXCTL) begin
        txctl_reg <= i_wdata;
      end
      if (link.ul_valid) begin
        rxdata_reg <= link.ul_data;
        rxslot_reg <= link.ul_slot;
        rxnew_reg <= 1'b1;
      end else if (rd_rx) begin
        rxnew_reg <= 1'b0;
      end
      o_rdata <= 32'h0;
      if (i_rd) begin
        unique case (i_addr)
          `LB_REG_TXDATA: o_rdata <= 32'(txdata_reg);
          `LB_REG_TXCTL: o_rdata <= txctl_reg;
          `LB_REG_STATUS: o_rdata <= status;
          `LB_REG_RXDATA: o_rdata <= 32'(rxdata_reg);
          `LB_REG_RXSLOT: o_rdata <= {29'h0, rxslot_reg};
          default: o_rdata <= 32'h0;
        endcase
      end
    end
  end

  assign link.blk_tick = tick_reg;
  assign link.start_cmd = start_reg;
  assign link.ul_assign = assign_reg;
  assign link.tbf_release = release_reg;
  assign link.dl_valid = dl_valid_reg;
  assign link.dl_slot = txctl_reg[2:0];
  assign link.dl_ctrl = txctl_reg[`LB_TXCTL_CTRL];
  assign link.dl_ptype = txctl_reg[`LB_TXCTL_PT_LO+1:`LB_TXCTL_PT_LO];
  assign link.dl_hdr_ok = txctl_reg[`LB_TXCTL_HDR];
  assign link.dl_data = txdata_reg;

endmodule

/* File: test/loopback_properties.sv */
// Concurrent checks on the link that joins the two loopback ends.
// Assumes one clock domain; TT03 matches the tester's parameter.
module loopback_properties #(
  parameter int TT03 = 20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Link signals
  input wire logic blk_tick,
  input wire logic start_cmd,
  input wire logic ul_assign,
  input wire logic tbf_release,
  input wire logic dl_valid,
  input wire logic dl_ctrl,
  input wire logic [1:0] dl_ptype,
  input wire logic ul_req,
  input wire logic ul_valid,
  input wire logic [2:0] ul_slot
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic [7:0] age_reg;
  logic [7:0] age_next;
  logic [15:0] wait_reg;
  logic [15:0] wait_next;
  logic loop_reg;
  logic loop_next;
  logic on_reg;
  logic on_next;

  // Counts saturate so a long idle never wraps into a false window
  assign age_next = blk_tick ? 8'h01 : age_reg + {7'h0, age_reg != 8'hff};
  assign wait_next = ul_assign ? 16'h0001 :
                     wait_reg + {15'h0, wait_reg != 16'hffff};
  assign loop_next = ul_assign | (loop_reg & ~tbf_release & ~start_cmd);
  assign on_next = ul_assign | ((dl_valid & dl_ctrl) ? ~dl_ptype[0] : on_reg);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      age_reg <= 8'hff;
      wait_reg <= 16'h0000;
      loop_reg <= 1'b0;
      on_reg <= 1'b1;
    end else begin
      age_reg <= age_next;
      wait_reg <= wait_next;
      loop_reg <= loop_next;
      on_reg <= on_next;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_req_after_start; start_cmd |=> ul_req; endproperty
  a_req_after_start: assert property (p_req_after_start)
    else $error("no uplink request after start");
  property p_assign_after_req; $rose(ul_req) |-> ##[0:2] ul_assign; endproperty
  a_assign_after_req: assert property (p_assign_after_req)
    else $error("uplink not assigned after request");
  property p_req_ends; ul_assign |=> !ul_req; endproperty
  a_req_ends: assert property (p_req_ends)
    else $error("request still up after assignment");
  property p_dl_after_tt03; dl_valid |-> wait_reg > 16'(TT03); endproperty
  a_dl_after_tt03: assert property (p_dl_after_tt03)
    else $error("downlink block before the settle time");
  property p_ul_in_loop; ul_valid |-> loop_reg; endproperty
  a_ul_in_loop: assert property (p_ul_in_loop)
    else $error("uplink block outside loopback");
  property p_ul_window;
    ul_valid && on_reg |-> age_reg inside {[8'h02:8'h09]};
  endproperty
  a_ul_window: assert property (p_ul_window)
    else $error("looped block outside the next block period");
  property p_ul_walk;
    ul_valid && on_reg |-> age_reg == {5'h0, ul_slot} + 8'h02;
  endproperty
  a_ul_walk: assert property (p_ul_walk)
    else $error("uplink slot out of order");
  property p_release_quiet; tbf_release |-> !ul_valid [*8]; endproperty
  a_release_quiet: assert property (p_release_quiet)
    else $error("uplink sent after release");
  property p_tick_gap; blk_tick |=> !blk_tick [*8]; endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("block periods too close");

  c_loop: cover property (ul_valid && on_reg);
  c_off: cover property (dl_valid && dl_ctrl && dl_ptype[0]);
  c_release: cover property (tbf_release && loop_reg);
endmodule

/* File: test/tb.sv */
// Self-checking bench: the tester end drives the device end over one link.
// Assumes shortened timer counts; all random values come from a fixed seed.
`include "loopback_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TT03 = 20;
  logic i_clk;
  logic i_arst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic multi_en;
  logic [7:0] dl_mask;
  logic [7:0] ul_mask;
  logic [2:0] dl_off;
  logic t3190;
  logic own_valid;
  logic [2:0] own_slot;
  logic [31:0] own_data;
  logic llc_valid;
  logic [31:0] llc_data;
  logic [31:0] llc_last;
  logic rlc_valid;
  logic rlc_ctrl;
  logic [31:0] rlc_data;
  logic [32:0] rlc_last;
  logic loop_active;
  logic submode_on;
  logic timers_hold;
  logic own_tx_allow;
  logic [31:0] got [8];
  logic [7:0] seen_mask;
  logic [31:0] r;
  int fail_count;
  int n_tests;
  int rlc_n;
  int llc_n;
  integer seed;

  loopback_if #(.DW(32)) u_link ();
  loopback_tester #(.DW(32), .BLOCK_CYCLES(64), .TT02_CYCLES(50),
    .TT03_CYCLES(TT03)) u_loopback_tester (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .link(u_link));
  loopback_device #(.DW(32)) u_loopback_device (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .link(u_link), .i_multislot_en(multi_en),
    .i_dl_ts_mask(dl_mask), .i_ul_ts_mask(ul_mask), .i_dl_offset(dl_off),
    .i_t3190_expired(t3190), .i_own_valid(own_valid),
    .i_own_slot(own_slot), .i_own_data(own_data), .o_llc_valid(llc_valid),
    .o_llc_data(llc_data), .o_rlc_valid(rlc_valid), .o_rlc_ctrl(rlc_ctrl),
    .o_rlc_data(rlc_data),
    .o_loop_active(loop_active), .o_submode_on(submode_on),
    .o_timers_hold(timers_hold), .o_own_tx_allow(own_tx_allow));
  loopback_properties #(.TT03(TT03)) u_loopback_properties (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .blk_tick(u_link.blk_tick),
    .start_cmd(u_link.start_cmd), .ul_assign(u_link.ul_assign),
    .tbf_release(u_link.tbf_release), .dl_valid(u_link.dl_valid),
    .dl_ctrl(u_link.dl_ctrl), .dl_ptype(u_link.dl_ptype),
    .ul_req(u_link.ul_req), .ul_valid(u_link.ul_valid),
    .ul_slot(u_link.ul_slot));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // Monitors and helpers
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (u_link.ul_valid === 1'b1) begin
      got[u_link.ul_slot] = u_link.ul_data;
      seen_mask[u_link.ul_slot] = 1'b1;
    end
    if (rlc_valid === 1'b1) begin
      rlc_n++;
      rlc_last = {rlc_ctrl, rlc_data};
    end
    if (llc_valid === 1'b1) llc_last = llc_data;
    if (llc_valid === 1'b1 && loop_active === 1'b1) llc_n++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic send(input logic [2:0] s, input logic c,
      input logic [1:0] p, input logic h, input logic [31:0] d);
    reg_wr(`LB_REG_TXDATA, d);
    reg_wr(`LB_REG_TXCTL, {25'h0, h, p, c, s});
    reg_wr(`LB_REG_CTRL, 32'h4);
  endtask

  // Source downlink slot of the n-th uplink slot; 8 means none
  function automatic int src_of(input int n, input logic [7:0] dm,
      input logic [7:0] um, input logic [2:0] off, input logic ms);
    int lst [8];
    int c;
    int rk;
    c = 0;
    rk = 0;
    for (int k = 0; k < 8; k++) begin
      if (dm[(int'(off) + k) % 8]) begin
        lst[c] = (int'(off) + k) % 8;
        c++;
      end
    end
    for (int k = 0; k < n; k++) rk += int'(um[k]);
    if (!um[n] || c == 0) return 8;
    if (!ms || c == 1) return lst[0];
    return lst[(rk < c) ? rk : c - 1];
  endfunction

  task automatic round(input logic [7:0] dm, input logic [7:0] um,
      input logic [2:0] off, input logic ms, input logic on);
    logic [31:0] d [8];
    int s;
    int r0;
    @(posedge i_clk);
    dl_mask <= dm;
    ul_mask <= um;
    dl_off <= off;
    multi_en <= ms;
    @(posedge u_link.blk_tick);
    r0 = rlc_n;
    // Slot 3 goes out with a bad header: looped, but kept from RLC/MAC
    for (int k = 0; k < 8; k++) begin
      d[k] = $random(seed);
      if (dm[k]) send(3'(k), 1'b0, 2'b00, k != 3, d[k]);
    end
    @(posedge u_link.blk_tick);
    #1 seen_mask = '0;
    repeat (12) @(posedge i_clk);
    #1 check(32'(rlc_n - r0), 32'($countones(dm) - int'(dm[3])));
    for (int n = 0; n < 8; n++) begin
      s = src_of(n, dm, um, off, ms);
      check(32'(seen_mask[n]), 32'(on && s < 8));
      if (on && s < 8) check(got[n], d[s]);
    end
  endtask

  task automatic mode(input logic [1:0] p);
    logic [31:0] d;
    d = $random(seed);
    send(3'd0, 1'b1, p, 1'b1, d);
    repeat (3) @(posedge i_clk);
    #1 check(32'(submode_on), 32'(!p[0]));
    check(32'(own_tx_allow), 32'(p[0]));
    check(rlc_last[31:0], d);
    check(32'(rlc_last[32]), 32'h1);
  endtask

  task automatic own_blk(input logic [31:0] dat, input logic exp_seen);
    @(posedge u_link.blk_tick);
    repeat (12) @(posedge i_clk);
    #1 seen_mask = '0;
    @(posedge i_clk);
    own_valid <= 1'b1;
    own_slot <= 3'd5;
    own_data <= dat;
    @(posedge i_clk);
    own_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 check(32'(seen_mask[5]), 32'(exp_seen));
    if (exp_seen) check(got[5], dat);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h9f34;
    {fail_count, n_tests, rlc_n, llc_n} = '0;
    {i_arst_n, addr, wdata, wr, rd, t3190, own_valid} = '0;
    {multi_en, dl_mask, ul_mask, dl_off, own_slot, own_data} = '0;
    seen_mask = '0;
    r = '0;
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    reg_rd(`LB_REG_TXCTL, r);
    check(r, `LB_TXCTL_RESET);
    reg_rd(8'h20, r);
    check(r, 32'h0);
    reg_wr(`LB_REG_CTRL, 32'h1);
    for (int k = 0; k < 20 && loop_active !== 1'b1; k++) @(negedge i_clk);
    check(32'(loop_active), 32'h1);
    check(32'(submode_on), 32'h1);
    check(32'(timers_hold), 32'h1);
    for (int k = 0; k < 40 && r[1:0] !== 2'h3; k++)
      reg_rd(`LB_REG_STATUS, r);
    check(32'(r[1:0]), 32'h3);
    round(8'h05, 8'hff, 3'd3, 1'b1, 1'b1);
    round(8'h10, 8'h0f, 3'd0, 1'b1, 1'b1);
    round(8'h3c, 8'hff, 3'd2, 1'b0, 1'b1);
    round(8'hff, 8'h81, 3'd7, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++)
      round(8'($random(seed)) | 8'h20, 8'($random(seed)),
            3'($random(seed)), 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) mode(2'(8'hb4 >> (2 * k)));
    own_blk(32'($random(seed)), 1'b0);
    mode(2'd1);
    own_blk(32'($random(seed)), 1'b1);
    round(8'h0f, 8'hff, 3'd0, 1'b1, 1'b0);
    check(32'(llc_n), 32'h0);
    reg_wr(`LB_REG_CTRL, 32'h2);
    repeat (3) @(negedge i_clk);
    check(32'(loop_active), 32'h0);
    check(32'(timers_hold), 32'h0);
    reg_wr(`LB_REG_CTRL, 32'h1);
    for (int k = 0; k < 20 && loop_active !== 1'b1; k++) @(negedge i_clk);
    check(32'(submode_on), 32'h1);
    @(posedge i_clk);
    t3190 <= 1'b1;
    @(posedge i_clk);
    t3190 <= 1'b0;
    repeat (2) @(negedge i_clk);
    check(32'(loop_active), 32'h0);
    // Back in idle, a good data block reaches the upper layer again
    repeat (30) @(posedge i_clk);
    r = $random(seed);
    send(3'd1, 1'b0, 2'b00, 1'b1, r);
    repeat (3) @(posedge i_clk);
    #1 check(llc_last, r);
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    end_of_test;
  end
endmodule
